// *** verilog/sfp_pkg.sv ***
// shared constants and types of the serial frame protocol engine
package sfp_pkg;
  localparam int unsigned FRAME_W    = 16;
  localparam int unsigned BYTE_W     = 8;
  localparam int unsigned PTR_W      = 3;
  localparam int unsigned PAY_W      = 12;
  localparam int unsigned CNT_W      = 8;
  localparam int unsigned IDX_W      = 4;
  localparam int unsigned MOD8_W     = 3;
  localparam int unsigned PIN_N      = 3;
  localparam int unsigned WR_BIT     = 15;
  localparam int unsigned PTR_MSB    = 14;
  localparam int unsigned PTR_LSB    = 12;
  localparam int unsigned PAY_MSB    = 11;
  localparam int unsigned HI_LSB     = 8;
  localparam int unsigned LO_MSB     = 7;
  localparam int unsigned HI_WR_BIT  = 7;
  localparam int unsigned HI_PTR_MSB = 6;
  localparam int unsigned HI_PTR_LSB = 4;
  typedef logic [FRAME_W-1:0] sfp_frame_t;
  typedef logic [PTR_W-1:0]   sfp_ptr_t;
  typedef logic [PAY_W-1:0]   sfp_pay_t;
  typedef logic [BYTE_W-1:0]  sfp_byte_t;
  localparam sfp_ptr_t              CSDS_PTR    = 3'h0;
  localparam sfp_ptr_t              CMPT_PTR    = 3'h1;
  localparam sfp_frame_t            REPLY_RST   = 16'h0000;
  localparam sfp_byte_t             BYTE_ZERO   = 8'h00;
  localparam logic [IDX_W-1:0]      IDX_MSB     = 4'hF;
  localparam logic [CNT_W-1:0]      CNT_HI_DONE = 8'h07;
  localparam logic [PIN_N-1:0]      PIN_RST     = 3'h5;
  typedef enum logic [2:0] {ST_IDLE, ST_HI_RES, ST_RD_WAIT, ST_RD_LATCH, ST_LO_RES} sfp_state_t;
endpackage : sfp_pkg

// *** verilog/sfp_link_if.sv ***
// carrier between frame shifter and protocol engine
`timescale 1ns/100ps
`default_nettype none
interface sfp_link_if;
  import sfp_pkg::*;
  logic       cs_act;
  logic       start_stb;
  logic       hi_stb;
  logic       end_stb;
  logic       end_ok;
  sfp_frame_t rx_word;
  sfp_frame_t reply;
  modport shf (output cs_act, start_stb, hi_stb, end_stb, end_ok, rx_word, input reply);
  modport eng (input cs_act, start_stb, hi_stb, end_stb, end_ok, rx_word, output reply);
endinterface : sfp_link_if
`default_nettype wire

// *** verilog/sfp_sync.sv ***
// two-stage synchroniser for the serial pins
`timescale 1ns/100ps
`default_nettype none
module sfp_sync
#(
  parameter logic [sfp_pkg::PIN_N-1:0] RST_VAL = sfp_pkg::PIN_RST
)
(
  input  wire logic                     clk,     // system clock
  input  wire logic                     rst_b,   // async reset
  input  wire logic [sfp_pkg::PIN_N-1:0] async_i, // raw pins
  output wire logic [sfp_pkg::PIN_N-1:0] sync_o   // synchronised pins
);
  import sfp_pkg::*;

  genvar g;
  generate
    for (g = 0; g < PIN_N; g++)
    begin : g_bit
      logic meta_r;
      logic hold_r;
      always_ff @(posedge clk or negedge rst_b)
      begin
        if (!rst_b)
        begin
          meta_r <= RST_VAL[g];
          hold_r <= RST_VAL[g];
        end
        else
        begin
          meta_r <= async_i[g];
          hold_r <= meta_r;
        end
      end
      assign sync_o[g] = hold_r;
    end
  endgenerate
endmodule : sfp_sync
`default_nettype wire

// *** verilog/sfp_shift.sv ***
// serial frame shifter: edge detection, bit count, in and out shifting
`timescale 1ns/100ps
`default_nettype none
module sfp_shift
(
  input  wire logic   clk,     // system clock
  input  wire logic   rst_b,   // async reset
  input  wire logic   cs_b_s,  // synced chip select, low active
  input  wire logic   sclk_s,  // synced serial clock
  input  wire logic   si_s,    // synced serial input
  sfp_link_if.shf     lnk,     // events to the engine
  output logic        so_o,    // serial output data
  output logic        so_oe_o  // serial output enable
);
  import sfp_pkg::*;

  logic             cs_d_r;
  logic             sclk_d_r;
  logic [CNT_W-1:0] cnt_r;
  logic [IDX_W-1:0] idx_r;
  logic             first_r;
  logic             past_r;
  sfp_frame_t       rx_r;
  logic             start_r;
  logic             hi_r;
  logic             end_r;
  logic             ok_r;
  logic             cs_fall;
  logic             cs_rise;
  logic             sc_fall;
  logic             sc_rise;

  assign cs_fall = cs_d_r & ~cs_b_s;
  assign cs_rise = ~cs_d_r & cs_b_s;
  // edges count only while selected
  assign sc_fall = ~cs_b_s & sclk_d_r & ~sclk_s;
  assign sc_rise = ~cs_b_s & ~sclk_d_r & sclk_s;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cs_d_r   <= 1'b1;
      sclk_d_r <= 1'b0;
    end
    else
    begin
      cs_d_r   <= cs_b_s;
      sclk_d_r <= sclk_s;
    end
  end

  // input sampled on falling serial clock, msb first
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt_r <= '0;
      rx_r  <= REPLY_RST;
    end
    else if (cs_fall)
      cnt_r <= '0;
    else if (sc_fall)
    begin
      rx_r  <= {rx_r[FRAME_W-2:0], si_s};
      cnt_r <= cnt_r + CNT_W'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      start_r <= 1'b0;
      hi_r    <= 1'b0;
      end_r   <= 1'b0;
      ok_r    <= 1'b0;
    end
    else
    begin
      start_r <= cs_fall;
      hi_r    <= sc_fall && (cnt_r == CNT_HI_DONE);
      end_r   <= cs_rise;
      ok_r    <= (cnt_r[MOD8_W-1:0] == '0) && (cnt_r != '0);
    end
  end

  // output index steps after each rising edge but the first
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      idx_r   <= IDX_MSB;
      first_r <= 1'b1;
      past_r  <= 1'b0;
    end
    else if (cs_fall)
    begin
      idx_r   <= IDX_MSB;
      first_r <= 1'b1;
      past_r  <= 1'b0;
    end
    else if (sc_rise)
    begin
      if (first_r)
        first_r <= 1'b0;
      else if (idx_r == '0)
        past_r <= 1'b1;
      else
        idx_r <= idx_r - IDX_W'(1);
    end
  end

  // reply leaves over the same edges that bring the command in
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      so_o    <= 1'b0;
      so_oe_o <= 1'b0;
    end
    else
    begin
      so_oe_o <= ~cs_b_s;
      so_o    <= cs_fall ? lnk.reply[IDX_MSB] : (~cs_b_s & ~past_r & lnk.reply[idx_r]);
    end
  end

  assign lnk.cs_act    = ~cs_b_s;
  assign lnk.start_stb = start_r;
  assign lnk.hi_stb    = hi_r;
  assign lnk.end_stb   = end_r;
  assign lnk.end_ok    = ok_r;
  assign lnk.rx_word   = rx_r;
endmodule : sfp_shift
`default_nettype wire

// *** verilog/sfp_engine.sv ***
// serial frame protocol engine: command decode and reply building
// What this block does
// - frame holds flag, pointer, twelve-bit payload
// - write applied only at chip select rise
// - write reply carries addressed register data
// - read data returned in following transfer
// - non-compact reply bit 15 is even parity
// - non-compact reply bits 14..12 echo pointer
// - reply payload holds register or feedback
// - first reply after reset is diagnosis
// - read needs two transfers, second carries command
// - compact upper byte runs after eight bits
// - compact lower byte runs at frame end
// - reply bytes pair with previous, current commands
// - reply shifts out with input simultaneously
// - deselected: ignore inputs, output floats
// - sample falling edge, drive after rising
// - non multiple of eight discarded, error
`timescale 1ns/100ps
`default_nettype none
module sfp_engine
(
  input  wire logic                clk,            // 100 MHz system clock
  input  wire logic                rst_b,          // async reset
  input  wire logic                cs_b_i,         // chip select pin
  input  wire logic                sclk_i,         // serial clock pin
  input  wire logic                si_i,           // serial input pin
  output logic                     so_o,           // serial output pin
  output logic                     so_oe_o,        // serial output enable
  output logic                     reg_wr_stb_o,   // register write pulse
  output sfp_pkg::sfp_ptr_t        reg_ptr_o,      // register pointer
  output sfp_pkg::sfp_pay_t        reg_wdata_o,    // register write data
  input  wire sfp_pkg::sfp_pay_t   reg_rdata_i,    // data of reg_ptr_o
  input  wire sfp_pkg::sfp_pay_t   sd_status_i,    // short diagnosis word
  output logic                     cmpt_hi_stb_o,  // upper byte command pulse
  output sfp_pkg::sfp_byte_t       cmpt_hi_cmd_o,  // upper byte command
  input  wire sfp_pkg::sfp_byte_t  cmpt_hi_res_i,  // upper byte result
  output logic                     cmpt_lo_stb_o,  // lower byte command pulse
  output sfp_pkg::sfp_byte_t       cmpt_lo_cmd_o,  // lower byte command
  input  wire sfp_pkg::sfp_byte_t  cmpt_lo_res_i,  // lower byte result
  output logic                     comm_err_o,     // sticky framing error
  input  wire logic                comm_err_clr_i  // clear framing error
);
  import sfp_pkg::*;

  sfp_link_if lnk ();

  logic [PIN_N-1:0] pins_s;
  sfp_state_t       state_r;
  sfp_frame_t       reply_r;
  logic             first_r;
  logic             cmpt_reply_r;
  sfp_ptr_t         rx_ptr;
  sfp_pay_t         rx_pay;
  logic             rx_wr;
  logic             rx_cmpt;
  logic             hi_cmpt;

  function automatic sfp_frame_t mk_reply(input sfp_ptr_t p, input sfp_pay_t d);
    mk_reply = {^{p, d}, p, d};
  endfunction : mk_reply

  sfp_sync u_sync
  (
    .clk     (clk),
    .rst_b   (rst_b),
    .async_i ({cs_b_i, sclk_i, si_i}),
    .sync_o  (pins_s)
  );

  sfp_shift u_shift
  (
    .clk     (clk),
    .rst_b   (rst_b),
    .cs_b_s  (pins_s[2]),
    .sclk_s  (pins_s[1]),
    .si_s    (pins_s[0]),
    .lnk     (lnk.shf),
    .so_o    (so_o),
    .so_oe_o (so_oe_o)
  );

  // frame fields
  assign rx_wr   = lnk.rx_word[WR_BIT];
  assign rx_ptr  = lnk.rx_word[PTR_MSB:PTR_LSB];
  assign rx_pay  = lnk.rx_word[PAY_MSB:0];
  // compact frames take the byte path instead of register access
  assign rx_cmpt = rx_wr && (rx_ptr == CMPT_PTR);
  // after eight bits the upper byte sits in the low half of the shifter
  assign hi_cmpt = lnk.rx_word[HI_WR_BIT] && (lnk.rx_word[HI_PTR_MSB:HI_PTR_LSB] == CMPT_PTR);

  assign lnk.reply = reply_r;

  // sequencing of command execution
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      state_r <= ST_IDLE;
    else
    begin
      case (state_r)
        ST_IDLE:
        begin
          if (lnk.hi_stb && hi_cmpt)
            state_r <= ST_HI_RES;
          else if (lnk.end_stb && lnk.end_ok)
            state_r <= rx_cmpt ? ST_LO_RES : ST_RD_WAIT;
        end
        ST_HI_RES:   state_r <= ST_IDLE;
        ST_RD_WAIT:  state_r <= ST_RD_LATCH;
        ST_RD_LATCH: state_r <= ST_IDLE;
        ST_LO_RES:   state_r <= ST_IDLE;
        default:     state_r <= ST_IDLE;
      endcase
    end
  end

  // register access strobes, issued only after chip select rises
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      reg_wr_stb_o <= 1'b0;
      reg_ptr_o    <= CSDS_PTR;
      reg_wdata_o  <= '0;
    end
    else
    begin
      reg_wr_stb_o <= 1'b0;
      if (state_r == ST_IDLE && lnk.end_stb && lnk.end_ok && !rx_cmpt)
      begin
        reg_wr_stb_o <= rx_wr;
        reg_ptr_o    <= rx_ptr;
        reg_wdata_o  <= rx_pay;
      end
    end
  end

  // compact byte commands
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cmpt_hi_stb_o <= 1'b0;
      cmpt_hi_cmd_o <= BYTE_ZERO;
      cmpt_lo_stb_o <= 1'b0;
      cmpt_lo_cmd_o <= BYTE_ZERO;
    end
    else
    begin
      cmpt_hi_stb_o <= 1'b0;
      cmpt_lo_stb_o <= 1'b0;
      if (state_r == ST_IDLE && lnk.hi_stb && hi_cmpt)
      begin
        cmpt_hi_stb_o <= 1'b1;
        cmpt_hi_cmd_o <= lnk.rx_word[LO_MSB:0];
      end
      if (state_r == ST_IDLE && lnk.end_stb && lnk.end_ok && rx_cmpt)
      begin
        cmpt_lo_stb_o <= 1'b1;
        cmpt_lo_cmd_o <= lnk.rx_word[LO_MSB:0];
      end
    end
  end

  // first frame after reset answers with the diagnosis word
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      first_r <= 1'b1;
    else if (lnk.start_stb)
      first_r <= 1'b0;
  end

  // reply word for the current and the next transfer
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      reply_r      <= REPLY_RST;
      cmpt_reply_r <= 1'b0;
    end
    else
    begin
      case (state_r)
        ST_IDLE:
        begin
          if (first_r && !lnk.cs_act)
          begin
            reply_r      <= mk_reply(CSDS_PTR, sd_status_i);
            cmpt_reply_r <= 1'b0;
          end
        end
        ST_HI_RES:
        begin
          reply_r[LO_MSB:0] <= cmpt_hi_res_i;
          cmpt_reply_r      <= 1'b1;
        end
        ST_RD_LATCH:
        begin
          // written register read back after the write took effect
          reply_r      <= mk_reply(reg_ptr_o, reg_rdata_i);
          cmpt_reply_r <= 1'b0;
        end
        ST_LO_RES:
        begin
          // lower half stays empty until the next upper command fills it
          reply_r      <= {cmpt_lo_res_i, BYTE_ZERO};
          cmpt_reply_r <= 1'b1;
        end
        default:
        begin
          reply_r      <= reply_r;
          cmpt_reply_r <= cmpt_reply_r;
        end
      endcase
    end
  end

  // sticky error for frames that are not whole bytes; a new error beats a clear
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      comm_err_o <= 1'b0;
    else if (lnk.end_stb && !lnk.end_ok)
      comm_err_o <= 1'b1;
    else if (comm_err_clr_i)
      comm_err_o <= 1'b0;
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  chk_first_reply: assert property (
    lnk.start_stb && $past(first_r) && $past(state_r == ST_IDLE)
    |-> reply_r[PTR_MSB:PTR_LSB] == CSDS_PTR && reply_r[PAY_MSB:0] == $past(sd_status_i, 2))
    else $error("first reply is not the diagnosis word");

  chk_wr_at_end: assert property (
    reg_wr_stb_o |-> $past(lnk.end_stb) && $past(lnk.end_ok) && $past(rx_wr) && !$past(rx_cmpt))
    else $error("register write without a completed write frame");

  chk_bad_no_wr: assert property (
    lnk.end_stb && !lnk.end_ok |=> !reg_wr_stb_o && !cmpt_lo_stb_o ##1 state_r == ST_IDLE)
    else $error("broken frame was executed");

  chk_err_sets: assert property (
    lnk.end_stb && !lnk.end_ok |=> comm_err_o)
    else $error("framing error not flagged");

  chk_rd_echo: assert property (
    state_r == ST_IDLE && lnk.end_stb && lnk.end_ok && !rx_cmpt
    |-> ##3 reply_r[PTR_MSB:PTR_LSB] == $past(rx_ptr, 3) && !cmpt_reply_r)
    else $error("reply does not echo the pointer");

  chk_rd_data: assert property (
    state_r == ST_RD_LATCH |=> reply_r[PAY_MSB:0] == $past(reg_rdata_i) && $past(reg_ptr_o) == reg_ptr_o)
    else $error("reply payload is not the register data");

  chk_reply_par: assert property (
    !cmpt_reply_r && state_r == ST_IDLE |-> reply_r[WR_BIT] == ^reply_r[PTR_MSB:0])
    else $error("reply parity wrong");

  chk_hi_result: assert property (
    state_r == ST_IDLE && lnk.hi_stb && hi_cmpt
    |=> cmpt_hi_stb_o ##1 reply_r[LO_MSB:0] == $past(cmpt_hi_res_i))
    else $error("upper byte result missing from lower reply byte");

  chk_lo_result: assert property (
    state_r == ST_IDLE && lnk.end_stb && lnk.end_ok && rx_cmpt
    |=> cmpt_lo_stb_o && cmpt_lo_cmd_o == $past(lnk.rx_word[LO_MSB:0])
    ##1 reply_r[FRAME_W-1:HI_LSB] == $past(cmpt_lo_res_i))
    else $error("lower byte result missing from next upper reply byte");

  chk_hiz_idle: assert property (
    !lnk.cs_act |=> !so_oe_o)
    else $error("serial output driven while deselected");

  chk_reply_hold: assert property (
    lnk.cs_act && state_r == ST_IDLE && !lnk.hi_stb |=> $stable(reply_r[FRAME_W-1:HI_LSB]))
    else $error("reply upper byte changed during the transfer");

  chk_cmpt_no_wr: assert property (
    state_r == ST_IDLE && lnk.end_stb && lnk.end_ok && rx_cmpt |=> !reg_wr_stb_o && state_r == ST_LO_RES)
    else $error("compact frame took the register path");

  cov_read_frame: cover property (
    lnk.end_stb && lnk.end_ok && !rx_wr ##3 state_r == ST_IDLE);

  cov_write_frame: cover property (
    lnk.end_stb && lnk.end_ok && rx_wr && !rx_cmpt ##1 reg_wr_stb_o);

  cov_compact_frame: cover property (
    cmpt_hi_stb_o ##[1:400] cmpt_lo_stb_o);

  cov_error_frame: cover property (
    lnk.end_stb && !lnk.end_ok ##1 comm_err_o);

  cov_first_frame: cover property (
    lnk.start_stb && first_r ##[1:400] lnk.end_stb && lnk.end_ok);
endmodule : sfp_engine
`default_nettype wire

// *** testbench/sfp_host_model.sv ***
// host master model: drives serial frames and collects the replies
`timescale 1ns/100ps
`default_nettype none
module sfp_host_model
#(
  parameter int HALF_NS = 80
)
(
  output logic      cs_b = 1'b1, // chip select, low active
  output logic      sclk = 1'b0, // serial clock, idles low
  output logic      si   = 1'b0, // serial data to the device
  input  wire logic so,          // serial data from the device
  input  wire logic so_oe        // device drives so
);
  logic so_last = 1'b0;
  logic so_line;

  // released line shows the inverse of its last driven value
  assign so_line = so_oe ? so : ~so_last;

  always @(negedge sclk)
    if (so_oe)
      so_last <= so;

  // one frame of the top nbits of tx; reply gathered over the same edges
  task automatic xfer(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
    rx = 16'h0000;
    #(HALF_NS) cs_b = 1'b0;            // sclk low at cs edges
    #(2*HALF_NS);
    for (int i = 0; i < nbits; i++)
    begin
      #(HALF_NS/2) sclk = 1'b1;
      #(HALF_NS/2) si = tx[15-i];      // msb first, changed after the rising edge
      #(HALF_NS/2) rx[15-i] = so_line; // taken just before the falling edge
      sclk = 1'b0;
      #(HALF_NS/2);
    end
    #(2*HALF_NS) cs_b = 1'b1;
    si = ~si;
    #(4*HALF_NS);                      // gap between frames
  endtask : xfer

  // clock and data activity while deselected
  task automatic idle_toggle(input int n);
    repeat (n)
    begin
      si = ~si;
      #(HALF_NS) sclk = 1'b1;
      #(HALF_NS) sclk = 1'b0;
    end
  endtask : idle_toggle
endmodule : sfp_host_model
`default_nettype wire

// *** testbench/tb.sv ***
// self-checking bench of the serial frame protocol engine
`timescale 1ns/100ps
`default_nettype none
module tb;
  import sfp_pkg::*;
  logic       clk = 1'b0;
  logic       rst_b;
  logic       cs_b;
  logic       sclk;
  logic       si;
  logic       so;
  logic       so_oe;
  logic       wr_stb;
  logic       hi_stb;
  logic       lo_stb;
  logic       err;
  logic       err_clr;
  sfp_ptr_t   ptr;
  sfp_pay_t   wdata;
  sfp_pay_t   rdata;
  sfp_pay_t   sd_status;
  sfp_byte_t  hi_cmd;
  sfp_byte_t  hi_res;
  sfp_byte_t  lo_cmd;
  sfp_byte_t  lo_res;
  sfp_pay_t   regs [8] = '{12'h00F, 12'h120, 12'h231, 12'h342, 12'h453, 12'h564, 12'h675, 12'h786};
  sfp_frame_t rx;
  int         n_fail = 0;
  int         num_checks = 0;
  int         n_wr = 0;
  int         n_wr_sel = 0;
  int         n_cmpt = 0;
  int         n_oe = 0;

  sfp_engine sfp_engine_inst (.clk(clk), .rst_b(rst_b), .cs_b_i(cs_b), .sclk_i(sclk), .si_i(si), .so_o(so),
    .so_oe_o(so_oe), .reg_wr_stb_o(wr_stb), .reg_ptr_o(ptr), .reg_wdata_o(wdata), .reg_rdata_i(rdata),
    .sd_status_i(sd_status), .cmpt_hi_stb_o(hi_stb), .cmpt_hi_cmd_o(hi_cmd), .cmpt_hi_res_i(hi_res),
    .cmpt_lo_stb_o(lo_stb), .cmpt_lo_cmd_o(lo_cmd), .cmpt_lo_res_i(lo_res), .comm_err_o(err),
    .comm_err_clr_i(err_clr));
  sfp_host_model sfp_host_model_inst (.cs_b(cs_b), .sclk(sclk), .si(si), .so(so), .so_oe(so_oe));

  // register file and compact responders
  assign rdata  = regs[ptr];
  assign hi_res = ~hi_cmd;
  assign lo_res = lo_cmd ^ 8'h5A;

  always #5 clk = ~clk;

  always @(posedge clk)
  begin
    if (wr_stb === 1'b1)
    begin
      regs[ptr] <= wdata;
      n_wr++;
      if (cs_b !== 1'b1)
        n_wr_sel++;
    end
    if (hi_stb === 1'b1 || lo_stb === 1'b1)
      n_cmpt++;
  end

  always @(posedge sclk)
    if (cs_b === 1'b1 && so_oe !== 1'b0)
      n_oe++;

  function automatic sfp_frame_t reply16(input sfp_ptr_t p, input sfp_pay_t d);
    return {^{p, d}, p, d};
  endfunction : reply16

  task automatic check(input sfp_frame_t got, input sfp_frame_t exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic stop_test;
    $display("checks=%0d mismatches=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : stop_test

  initial
  begin
    repeat (100000) @(posedge clk);
    n_fail++;
    stop_test();
  end

  initial
  begin
    rst_b     = 1'b0;
    err_clr   = 1'b0;
    sd_status = 12'h5A3;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    check({15'h0000, so_oe}, 16'h0000);
    sfp_host_model_inst.xfer({1'b0, 3'h2, 12'h000}, 16, rx);
    check(rx, reply16(CSDS_PTR, 12'h5A3));
    sfp_host_model_inst.xfer({1'b1, 3'h3, 12'hABC}, 16, rx);
    check(rx, reply16(3'h2, 12'h231));
    check(16'(n_wr), 16'h0001);
    check(16'(n_wr_sel), 16'h0000);
    sfp_host_model_inst.xfer({1'b0, 3'h0, 12'h000}, 16, rx); // no-op ahead of compact frames
    check(rx, reply16(3'h3, 12'hABC));
    $display("test read_write done");

    sfp_host_model_inst.xfer({8'h95, 8'h3C}, 16, rx);
    check({8'h00, rx[7:0]}, 16'h006A);
    sfp_host_model_inst.xfer({8'h9E, 8'hC3}, 16, rx);
    check(rx, 16'h6661);
    sfp_host_model_inst.xfer({1'b0, 3'h5, 12'h000}, 16, rx);
    check(rx, 16'h9900);
    check(16'(n_wr), 16'h0001);
    check(16'(n_cmpt), 16'h0004);
    $display("test compact done");

    sfp_host_model_inst.xfer({1'b1, 3'h5, 12'h000}, 12, rx);
    check({15'h0000, err}, 16'h0001);
    check(16'(n_wr), 16'h0001);
    @(posedge clk);
    err_clr <= 1'b1;
    @(posedge clk);
    err_clr <= 1'b0;
    repeat (2) @(posedge clk);
    check({15'h0000, err}, 16'h0000);
    sfp_host_model_inst.xfer({1'b0, 3'h7, 12'h000}, 8, rx);
    check({15'h0000, err}, 16'h0000);
    sfp_host_model_inst.xfer({1'b0, 3'h6, 12'h000}, 16, rx);
    // byte frame decoded with the stale upper byte: read of pointer 0
    check(rx, reply16(3'h0, 12'h00F));
    sfp_host_model_inst.xfer(16'h0000, 16, rx);
    check(rx, reply16(3'h6, 12'h675));
    $display("test framing done");

    sfp_host_model_inst.idle_toggle(20);
    check(16'(n_oe), 16'h0000);
    check(16'(n_wr), 16'h0001);
    sfp_host_model_inst.xfer(16'h0000, 16, rx);
    check(rx, reply16(3'h0, 12'h00F));
    $display("test deselect done");
    stop_test();
  end
endmodule : tb
`default_nettype wire
